// [design/ambient_comp_regs.sv]
`timescale 1ns/10ps
// Behaviour
// - skip field discards sequences between fast admits
// - full power hold-off is count times 16
// - low power hold-off is count times 4
// - power-down timeout scales hold count by factor
// - force bit makes all stages recalibrate
// - restart bit restarts sequence, then self-clears
// - near-touch recalibration level is field times 16
// - detection rate is field times 16
// - full and low power recalibration times held
// - per-stage enable gates low-threshold interrupt sources
// - pin setup: off, input, low or high output
// - input trigger: low, rise, fall, high level
// - interrupt polarity bit selects active level
module ambient_comp_regs (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [touch_amb_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [touch_amb_pkg::DATA_W-1:0] reg_wdata,
  output logic [touch_amb_pkg::DATA_W-1:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic seq_done,
  input wire logic low_power_mode,
  input wire logic near_touch,
  input wire logic [touch_amb_pkg::STAGES-1:0] low_exceed,
  input wire logic irq_polarity,
  input wire logic gpio_drive,
  input wire logic gpio_pin_in,
  output logic gpio_pin_out,
  output logic gpio_pin_oe_n,
  output logic gpio_trigger,
  output logic irq_out,
  output logic ff_admit,
  output logic cal_suspend,
  output logic force_recal,
  output logic seq_restart,
  output logic power_down_req,
  output logic [11:0] near_recal_level,
  output logic [9:0] near_detect_rate,
  output logic [9:0] fp_near_recal_time,
  output logic [5:0] lp_near_recal_time
);
  logic [15:0] amb_q, amb_d;
  logic [15:0] lvl_q, lvl_d;
  logic [15:0] recal_q, recal_d;
  logic [15:0] irqpin_q, irqpin_d;
  logic [15:0] rdata_q, rdata_d;
  logic rvalid_q, rvalid_d;
  logic [3:0] skip_q, skip_d;
  logic admit_q, admit_d;
  logic [touch_amb_pkg::PD_W-1:0] pd_q, pd_d;
  logic pd_req_q, pd_req_d;
  logic in_s1_q, in_s2_q, in_s3_q;
  logic pin_out_q, pin_out_d, pin_oe_n_q, pin_oe_n_d, trig_q, trig_d;
  logic irq_q, irq_d;
  logic [touch_amb_pkg::STAGES-1:0] low_src;
  logic [3:0] fp_hold, lp_hold, skip_lim;
  logic [touch_amb_pkg::PD_W-1:0] pd_limit;
  logic wr_amb, wr_restart;
  touch_amb_pkg::pin_setup_t pin_setup;
  touch_amb_pkg::pin_trig_t pin_trig;
  holdoff_if hif ();

  function automatic logic hit(input logic [touch_amb_pkg::ADDR_W-1:0] a,
                               input logic [touch_amb_pkg::ADDR_W-1:0] ofs);
    hit = (a == ofs);
  endfunction

  function automatic logic [touch_amb_pkg::PD_W-1:0] pd_scale(input logic [3:0] fp, input logic [1:0] code);
    logic [5:0] mult;
    mult = touch_amb_pkg::PD_BASE_MULT + {2'h0, code, 2'h0};
    // both factors widened first, so the product (at most 15 * 32) cannot wrap
    pd_scale = {5'h00, fp} * {3'h0, mult};
  endfunction

  assign fp_hold = amb_q[touch_amb_pkg::FP_HOLD_LSB +: 4];
  assign lp_hold = amb_q[touch_amb_pkg::LP_HOLD_LSB +: 4];
  // codes above the top legal value behave as the top value
  assign skip_lim = (amb_q[touch_amb_pkg::SKIP_LSB +: 4] > touch_amb_pkg::SKIP_MAX) ?
                    touch_amb_pkg::SKIP_MAX : amb_q[touch_amb_pkg::SKIP_LSB +: 4];
  assign pd_limit = pd_scale(fp_hold, amb_q[touch_amb_pkg::PD_DELAY_LSB +: 2]);
  assign pin_setup = touch_amb_pkg::pin_setup_t'(irqpin_q[touch_amb_pkg::PIN_SETUP_LSB +: 2]);
  assign pin_trig = touch_amb_pkg::pin_trig_t'(irqpin_q[touch_amb_pkg::PIN_TRIG_LSB +: 2]);
  assign wr_amb = reg_wr && hit(reg_addr, touch_amb_pkg::AMB_FILTER_TIMING_OFS);
  assign wr_restart = wr_amb && reg_wdata[touch_amb_pkg::RESTART_BIT];

  // register file
  always_comb begin
    amb_d = amb_q;
    lvl_d = lvl_q;
    recal_d = recal_q;
    irqpin_d = irqpin_q;
    // restart bit drops after one cycle; a new write of the bit in that cycle keeps it set
    amb_d[touch_amb_pkg::RESTART_BIT] = 1'b0;
    if (wr_amb) begin
      amb_d = reg_wdata;
    end
    if (reg_wr && hit(reg_addr, touch_amb_pkg::PROX_LEVELS_OFS)) begin
      lvl_d = reg_wdata;
    end
    if (reg_wr && hit(reg_addr, touch_amb_pkg::PROX_RECAL_TIMES_OFS)) begin
      recal_d = reg_wdata;
    end
    if (reg_wr && hit(reg_addr, touch_amb_pkg::LOW_IRQ_PIN_OFS)) begin
      // unused bits are not stored, so a stray one from the host is harmless
      irqpin_d = reg_wdata & touch_amb_pkg::LOW_IRQ_PIN_MASK;
    end
    rvalid_d = reg_rd;
    rdata_d = 16'h0000;
    if (reg_rd) begin
      case (reg_addr)
        touch_amb_pkg::AMB_FILTER_TIMING_OFS: rdata_d = amb_q;
        touch_amb_pkg::PROX_LEVELS_OFS: rdata_d = lvl_q;
        touch_amb_pkg::PROX_RECAL_TIMES_OFS: rdata_d = recal_q;
        touch_amb_pkg::LOW_IRQ_PIN_OFS: rdata_d = irqpin_q;
        default: rdata_d = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      amb_q <= touch_amb_pkg::AMB_FILTER_TIMING_RST;
      lvl_q <= touch_amb_pkg::PROX_LEVELS_RST;
      recal_q <= touch_amb_pkg::PROX_RECAL_TIMES_RST;
      irqpin_q <= touch_amb_pkg::LOW_IRQ_PIN_RST;
      rdata_q <= 16'h0000;
      rvalid_q <= 1'b0;
    end else begin
      amb_q <= amb_d;
      lvl_q <= lvl_d;
      recal_q <= recal_d;
      irqpin_q <= irqpin_d;
      rdata_q <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end

  assign reg_rdata = rdata_q;
  assign reg_rvalid = rvalid_q;
  assign force_recal = amb_q[touch_amb_pkg::FORCE_BIT];
  assign seq_restart = amb_q[touch_amb_pkg::RESTART_BIT];
  assign near_recal_level = {lvl_q[touch_amb_pkg::LVL_LSB +: 8], 4'h0};
  assign near_detect_rate = {lvl_q[touch_amb_pkg::RATE_LSB +: 6], 4'h0};
  assign fp_near_recal_time = recal_q[touch_amb_pkg::FP_RECAL_LSB +: 10];
  assign lp_near_recal_time = recal_q[touch_amb_pkg::LP_RECAL_LSB +: 6];

  // fast filter skip and power-down timeout, both counted in whole sequences
  always_comb begin
    skip_d = skip_q;
    admit_d = 1'b0;
    pd_d = pd_q;
    pd_req_d = 1'b0;
    if (seq_restart) begin
      skip_d = 4'h0;
    end else if (seq_done) begin
      if (skip_q == 4'h0) begin
        admit_d = 1'b1;
        skip_d = skip_lim;
      end else begin
        skip_d = skip_q - 1'b1;
      end
    end
    // any touch or restart, or low power already, keeps the timeout from running
    if (seq_restart || near_touch || low_power_mode) begin
      pd_d = '0;
    end else if (seq_done && pd_limit != '0 && pd_q != pd_limit) begin
      pd_d = pd_q + 1'b1;
      pd_req_d = (pd_q + 1'b1 == pd_limit);
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      skip_q <= 4'h0;
      admit_q <= 1'b0;
      pd_q <= '0;
      pd_req_q <= 1'b0;
    end else begin
      skip_q <= skip_d;
      admit_q <= admit_d;
      pd_q <= pd_d;
      pd_req_q <= pd_req_d;
    end
  end

  assign ff_admit = admit_q;
  assign power_down_req = pd_req_q;

  // calibration hold-off after a near touch
  assign hif.start = near_touch;
  assign hif.step = seq_done;
  assign hif.load = low_power_mode ?
                    touch_amb_pkg::HOLD_W'({lp_hold, 2'h0}) :
                    touch_amb_pkg::HOLD_W'({fp_hold, 4'h0});
  assign cal_suspend = hif.busy;

  seq_holdoff_timer u_holdoff (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .t(hif.tmr)
  );

  // interrupt sources and general-purpose pin
  genvar g;
  generate
    for (g = 0; g < touch_amb_pkg::STAGES; g++) begin : g_low_src
      assign low_src[g] = irqpin_q[g] & low_exceed[g];
    end
  endgenerate

  always_comb begin
    irq_d = irq_polarity ? (|low_src) : !(|low_src);
    pin_out_d = 1'b0;
    pin_oe_n_d = 1'b1;
    trig_d = 1'b0;
    case (pin_setup)
      touch_amb_pkg::PIN_OUT_LOW: begin
        pin_out_d = !gpio_drive;
        pin_oe_n_d = 1'b0;
      end
      touch_amb_pkg::PIN_OUT_HIGH: begin
        pin_out_d = gpio_drive;
        pin_oe_n_d = 1'b0;
      end
      touch_amb_pkg::PIN_IN: begin
        case (pin_trig)
          touch_amb_pkg::TRIG_LOW_LEVEL: trig_d = !in_s2_q;
          touch_amb_pkg::TRIG_RISE: trig_d = in_s2_q && !in_s3_q;
          touch_amb_pkg::TRIG_FALL: trig_d = !in_s2_q && in_s3_q;
          default: trig_d = in_s2_q;
        endcase
      end
      default: pin_oe_n_d = 1'b1;
    endcase
  end

  // in_s1_q feeds only in_s2_q; edge logic looks at the second stage onward
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      in_s1_q <= 1'b0;
      in_s2_q <= 1'b0;
      in_s3_q <= 1'b0;
      irq_q <= 1'b1;
      pin_out_q <= 1'b0;
      pin_oe_n_q <= 1'b1;
      trig_q <= 1'b0;
    end else begin
      in_s1_q <= gpio_pin_in;
      in_s2_q <= in_s1_q;
      in_s3_q <= in_s2_q;
      irq_q <= irq_d;
      pin_out_q <= pin_out_d;
      pin_oe_n_q <= pin_oe_n_d;
      trig_q <= trig_d;
    end
  end

  assign irq_out = irq_q;
  assign gpio_pin_out = pin_out_q;
  assign gpio_pin_oe_n = pin_oe_n_q;
  assign gpio_trigger = trig_q;

  sequence s_restart_write;
    wr_restart;
  endsequence
  sequence s_restart_pulse;
    seq_restart ##1 (!seq_restart || $past(wr_restart));
  endsequence
  sequence s_rise_seen;
    !in_s2_q ##1 in_s2_q;
  endsequence

  a_restart_pulse: assert property (@(posedge sys_clk) disable iff (sys_rst)
    s_restart_write |=> s_restart_pulse)
    else $error("restart did not pulse and self-clear");
  a_restart_read: assert property (@(posedge sys_clk) disable iff (sys_rst)
    reg_rd && hit(reg_addr, touch_amb_pkg::AMB_FILTER_TIMING_OFS) && !seq_restart
    |=> reg_rvalid && !reg_rdata[touch_amb_pkg::RESTART_BIT])
    else $error("restart bit read back as one");
  a_force_write: assert property (@(posedge sys_clk) disable iff (sys_rst)
    wr_amb |=> force_recal == $past(reg_wdata[touch_amb_pkg::FORCE_BIT]))
    else $error("forced calibration not taken from write");
  a_skip_admit: assert property (@(posedge sys_clk) disable iff (sys_rst)
    seq_done && !seq_restart && skip_q == 4'h0 |=> ff_admit && skip_q == $past(skip_lim))
    else $error("fast filter admit missed");
  a_level_scale: assert property (@(posedge sys_clk) disable iff (sys_rst)
    reg_wr && hit(reg_addr, touch_amb_pkg::PROX_LEVELS_OFS)
    |=> near_recal_level == {$past(reg_wdata[7:0]), 4'h0} &&
        near_detect_rate == {$past(reg_wdata[13:8]), 4'h0})
    else $error("near-touch level or rate not scaled by 16");
  a_fp_holdoff: assert property (@(posedge sys_clk) disable iff (sys_rst)
    near_touch && !low_power_mode && fp_hold != 4'h0 |=> cal_suspend [*2])
    else $error("full power hold-off not started");
  a_lp_holdoff: assert property (@(posedge sys_clk) disable iff (sys_rst)
    near_touch && low_power_mode && lp_hold == 4'h0 |=> !cal_suspend)
    else $error("low power hold-off with zero count");
  a_irq_level: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (|(irqpin_q[7:0] & low_exceed)) |=> irq_out == $past(irq_polarity))
    else $error("interrupt not driven at selected level");
  a_pin_drive: assert property (@(posedge sys_clk) disable iff (sys_rst)
    pin_setup == touch_amb_pkg::PIN_OUT_LOW && gpio_drive |=> !gpio_pin_out && !gpio_pin_oe_n)
    else $error("active-low pin output wrong");
  a_pin_rise: assert property (@(posedge sys_clk) disable iff (sys_rst)
    pin_setup == touch_amb_pkg::PIN_IN && pin_trig == touch_amb_pkg::TRIG_RISE
    ##0 s_rise_seen |=> gpio_trigger)
    else $error("rising edge trigger missed");
endmodule // ambient_comp_regs

// [common/touch_amb_pkg.sv]
package touch_amb_pkg;
  localparam int ADDR_W = 10;
  localparam int DATA_W = 16;
  localparam int STAGES = 8;

  localparam logic [9:0] AMB_FILTER_TIMING_OFS = 10'h002;
  localparam logic [9:0] PROX_LEVELS_OFS = 10'h003;
  localparam logic [9:0] PROX_RECAL_TIMES_OFS = 10'h004;
  localparam logic [9:0] LOW_IRQ_PIN_OFS = 10'h005;

  localparam logic [15:0] AMB_FILTER_TIMING_RST = 16'h0ff0;
  localparam logic [15:0] PROX_LEVELS_RST = 16'h0140;
  localparam logic [15:0] PROX_RECAL_TIMES_RST = 16'hffff;
  localparam logic [15:0] LOW_IRQ_PIN_RST = 16'h0000;
  // bits 11:8 of the irq/pin register hold nothing and read as zero
  localparam logic [15:0] LOW_IRQ_PIN_MASK = 16'hf0ff;

  localparam int SKIP_LSB = 0;
  localparam int FP_HOLD_LSB = 4;
  localparam int LP_HOLD_LSB = 8;
  localparam int PD_DELAY_LSB = 12;
  localparam int FORCE_BIT = 14;
  localparam int RESTART_BIT = 15;
  localparam int LVL_LSB = 0;
  localparam int RATE_LSB = 8;
  localparam int FP_RECAL_LSB = 0;
  localparam int LP_RECAL_LSB = 10;
  localparam int PIN_SETUP_LSB = 12;
  localparam int PIN_TRIG_LSB = 14;

  localparam logic [3:0] SKIP_MAX = 4'hb;
  localparam int HOLD_W = 10;
  localparam int FP_HOLD_SHIFT = 4;
  localparam int LP_HOLD_SHIFT = 2;
  localparam int NEAR_SCALE_SHIFT = 4;
  // timeout in sequences = fp count * 16 * (1.25 + 0.25*code) = fp * (20 + 4*code)
  localparam logic [5:0] PD_BASE_MULT = 6'h14;
  localparam int PD_W = 9;

  typedef enum logic [1:0] {
    PIN_OFF = 2'h0,
    PIN_IN = 2'h1,
    PIN_OUT_LOW = 2'h2,
    PIN_OUT_HIGH = 2'h3
  } pin_setup_t;

  typedef enum logic [1:0] {
    TRIG_LOW_LEVEL = 2'h0,
    TRIG_RISE = 2'h1,
    TRIG_FALL = 2'h2,
    TRIG_HIGH_LEVEL = 2'h3
  } pin_trig_t;
endpackage

// [common/holdoff_if.sv]
`timescale 1ns/10ps
interface holdoff_if;
  logic start;
  logic step;
  logic [touch_amb_pkg::HOLD_W-1:0] load;
  logic busy;
  modport ctl (output start, output step, output load, input busy);
  modport tmr (input start, input step, input load, output busy);
endinterface

// [design/seq_holdoff_timer.sv]
`timescale 1ns/10ps
module seq_holdoff_timer (
  input wire logic sys_clk,
  input wire logic sys_rst,
  holdoff_if.tmr t
);
  logic [touch_amb_pkg::HOLD_W-1:0] count_q;
  logic [touch_amb_pkg::HOLD_W-1:0] count_d;

  // a fresh start wins over a step in the same cycle, so a new touch re-arms fully
  always_comb begin
    count_d = count_q;
    if (t.start) begin
      count_d = t.load;
    end else if (t.step && count_q != '0) begin
      count_d = count_q - 1'b1;
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      count_q <= '0;
    end else begin
      count_q <= count_d;
    end
  end

  assign t.busy = (count_q != '0);

  a_hold_reload: assert property (@(posedge sys_clk) disable iff (sys_rst)
    t.start |=> count_q == $past(t.load))
    else $error("hold-off count not loaded on start");
  a_hold_step: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !t.start && t.step && t.busy |=> count_q == $past(count_q) - 1'b1)
    else $error("hold-off count did not step down");
endmodule // seq_holdoff_timer

// [bench/host_port_model.sv]
`timescale 1ns/10ps
module host_port_model (
  input wire logic sys_clk,
  output logic reg_wr,
  output logic reg_rd,
  output logic [touch_amb_pkg::ADDR_W-1:0] reg_addr,
  output logic [touch_amb_pkg::DATA_W-1:0] reg_wdata,
  input wire logic [touch_amb_pkg::DATA_W-1:0] reg_rdata,
  input wire logic reg_rvalid
);
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 10'h3ff;
    reg_wdata = 16'h0000;
  end
  // idle bus shows inverted values so a stale address never looks valid
  task automatic wr(input logic [9:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    #1;
    reg_addr = a;
    reg_wdata = (a == touch_amb_pkg::LOW_IRQ_PIN_OFS) ? (d & 16'hf0ff) : d;
    reg_wr = 1'b1;
    @(posedge sys_clk);
    #1;
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~reg_wdata;
  endtask
  task automatic rd(input logic [9:0] a, output logic [15:0] d, output logic v);
    @(posedge sys_clk);
    #1;
    reg_addr = a;
    reg_rd = 1'b1;
    @(posedge sys_clk);
    #1;
    reg_rd = 1'b0;
    reg_addr = ~a;
    v = reg_rvalid;
    d = reg_rdata;
  endtask
endmodule // host_port_model

// [bench/ambient_comp_regs_tb_top.sv]
`timescale 1ns/10ps
module ambient_comp_regs_tb_top;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic reg_wr, reg_rd, reg_rvalid;
  logic [9:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata;
  logic seq_done = 1'b0, low_power_mode = 1'b0, near_touch = 1'b0, irq_polarity = 1'b0;
  logic gpio_drive = 1'b0, gpio_pin_in = 1'b0;
  logic [7:0] low_exceed = 8'h00;
  logic gpio_pin_out, gpio_pin_oe_n, gpio_trigger, irq_out, ff_admit, cal_suspend;
  logic force_recal, seq_restart, power_down_req;
  logic [11:0] near_recal_level;
  logic [9:0] near_detect_rate, fp_near_recal_time;
  logic [5:0] lp_near_recal_time;
  int fail_count = 0;
  int cmp_count = 0;

  always #20 sys_clk = ~sys_clk;

  ambient_comp_regs u_ambient_comp_regs (.sys_clk(sys_clk), .sys_rst(sys_rst), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .seq_done(seq_done), .low_power_mode(low_power_mode),
    .near_touch(near_touch), .low_exceed(low_exceed), .irq_polarity(irq_polarity),
    .gpio_drive(gpio_drive), .gpio_pin_in(gpio_pin_in), .gpio_pin_out(gpio_pin_out),
    .gpio_pin_oe_n(gpio_pin_oe_n), .gpio_trigger(gpio_trigger), .irq_out(irq_out),
    .ff_admit(ff_admit), .cal_suspend(cal_suspend), .force_recal(force_recal),
    .seq_restart(seq_restart), .power_down_req(power_down_req), .near_recal_level(near_recal_level),
    .near_detect_rate(near_detect_rate), .fp_near_recal_time(fp_near_recal_time),
    .lp_near_recal_time(lp_near_recal_time));

  host_port_model u_host_port_model (.sys_clk(sys_clk), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));

  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic rd_chk(input logic [9:0] a, input logic [15:0] exp);
    logic [15:0] d;
    logic v;
    u_host_port_model.rd(a, d, v);
    chk("rvalid", 16'h0001, {15'h0, v});
    chk("rdata", exp, d);
  endtask

  task automatic seq();
    @(posedge sys_clk);
    #1 seq_done = 1'b1;
    @(posedge sys_clk);
    #1 seq_done = 1'b0;
  endtask

  task automatic near();
    @(posedge sys_clk);
    #1 near_touch = 1'b1;
    @(posedge sys_clk);
    #1 near_touch = 1'b0;
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    #2000000;
    fail_count++;
    finish_test();
  end

  initial begin
    logic [15:0] n, f;
    static logic [3:0] skip_tab [4] = '{4'h0, 4'h2, 4'hb, 4'hf};
    wait_cyc(12);
    sys_rst = 1'b0;
    rd_chk(10'h002, 16'h0ff0);
    rd_chk(10'h003, 16'h0140);
    rd_chk(10'h004, 16'hffff);
    rd_chk(10'h005, 16'h0000);
    chk("level", 16'h0400, {4'h0, near_recal_level});
    chk("rate", 16'h0010, {6'h0, near_detect_rate});
    u_host_port_model.wr(10'h001, 16'hffff);
    rd_chk(10'h001, 16'h0000);
    for (int i = 0; i < 4; i++) begin
      u_host_port_model.wr(10'h002, 16'h0ff0 | skip_tab[i]);
      n = 0;
      repeat (24) begin
        seq();
        if (ff_admit === 1'b1) n++;
      end
      chk("admits", 16'(24 / ((skip_tab[i] > 4'hb ? 11 : skip_tab[i]) + 1)), n);
    end
    u_host_port_model.wr(10'h002, 16'hcff0);
    chk("restart", 16'h0001, {15'h0, seq_restart});
    chk("force", 16'h0001, {15'h0, force_recal});
    wait_cyc(1);
    chk("restart_end", 16'h0000, {15'h0, seq_restart});
    rd_chk(10'h002, 16'h4ff0);
    u_host_port_model.wr(10'h002, 16'h0110);
    chk("force_off", 16'h0000, {15'h0, force_recal});
    for (int lp = 0; lp < 2; lp++) begin
      low_power_mode = lp[0];
      near();
      chk("suspend", 16'h0001, {15'h0, cal_suspend});
      n = 0;
      while (cal_suspend === 1'b1 && n < 40) begin
        seq();
        n++;
        wait_cyc(1);
      end
      chk("hold", lp ? 16'd4 : 16'd16, n);
    end
    low_power_mode = 1'b0;
    for (int c = 0; c < 4; c++) begin
      u_host_port_model.wr(10'h002, 16'h0010 | 16'(c << 12));
      near();
      n = 0;
      f = 0;
      while (f == 0 && n < 40) begin
        seq();
        n++;
        if (power_down_req === 1'b1) f = n;
      end
      chk("timeout", 16'(20 + 4 * c), f);
    end
    // a zero low power count must not suspend calibration at all
    low_power_mode = 1'b1;
    near();
    chk("lp_zero", 16'h0000, {15'h0, cal_suspend});
    low_power_mode = 1'b0;
    u_host_port_model.wr(10'h003, 16'h3fff);
    chk("level", 16'h0ff0, {4'h0, near_recal_level});
    chk("rate", 16'h03f0, {6'h0, near_detect_rate});
    rd_chk(10'h003, 16'h3fff);
    u_host_port_model.wr(10'h004, 16'h8005);
    chk("fp_recal", 16'h0005, {6'h0, fp_near_recal_time});
    chk("lp_recal", 16'h0020, {10'h0, lp_near_recal_time});
    for (int k = 0; k < 8; k++) begin
      irq_polarity = k[0];
      u_host_port_model.wr(10'h005, 16'h0f00 | 16'(1 << k));
      rd_chk(10'h005, 16'(1 << k));
      low_exceed = 8'(1 << k);
      wait_cyc(2);
      chk("irq_on", {15'h0, k[0]}, {15'h0, irq_out});
      low_exceed = ~8'(1 << k);
      wait_cyc(2);
      chk("irq_off", {15'h0, ~k[0]}, {15'h0, irq_out});
    end
    gpio_drive = 1'b1;
    for (int s = 0; s < 4; s++) begin
      u_host_port_model.wr(10'h005, 16'(s << 12));
      wait_cyc(2);
      chk("pin_oe_n", {15'h0, s < 2}, {15'h0, gpio_pin_oe_n});
      if (s >= 2) chk("pin_out", {15'h0, s == 3}, {15'h0, gpio_pin_out});
    end
    // level triggers hold while the pin is active, edges give one pulse
    for (int t = 0; t < 4; t++) begin
      gpio_pin_in = ~t[0];
      u_host_port_model.wr(10'h005, 16'h1000 | 16'(t << 14));
      wait_cyc(6);
      chk("trig_idle", 16'h0000, {15'h0, gpio_trigger});
      gpio_pin_in = t[0];
      n = 0;
      repeat (8) begin
        wait_cyc(1);
        if (gpio_trigger === 1'b1) n++;
      end
      if (t == 1 || t == 2) chk("trig_edge", 16'h0001, n);
      else chk("trig_level", 16'h0001, {15'h0, gpio_trigger});
    end
    // mid-run reset throws away everything written so far
    sys_rst = 1'b1;
    wait_cyc(2);
    sys_rst = 1'b0;
    rd_chk(10'h002, 16'h0ff0);
    rd_chk(10'h004, 16'hffff);
    rd_chk(10'h005, 16'h0000);
    chk("oe_rst", 16'h0001, {15'h0, gpio_pin_oe_n});
    finish_test();
  end
endmodule // ambient_comp_regs_tb_top
